// ---- opc_pkg.sv ----
// constants, register map and field layout of the optical port pin control block
// assumes a 125 MHz mclk and AXI4-Lite with 16-bit byte addresses
package opc_pkg;
   // printed offsets are word indices; byte address is four times the index
   localparam logic [15:0] REG_PINCFG_IDX = 16'h2456;
   localparam logic [15:0] REG_OPTCFG_IDX = 16'h2457;
   localparam logic [15:0] REG_STATUS_IDX = 16'h2458;
   localparam logic [15:0] ADDR_PINCFG = {REG_PINCFG_IDX[13:0], 2'b00};
   localparam logic [15:0] ADDR_OPTCFG = {REG_OPTCFG_IDX[13:0], 2'b00};
   localparam logic [15:0] ADDR_STATUS = {REG_STATUS_IDX[13:0], 2'b00};

   // pin configuration fields
   localparam int POS_TX_INVERT = 0;
   localparam int POS_TX_MODULATE_EN = 1;
   localparam int POS_TX_PIN_SELECT = 2;
   localparam int POS_EEPROM_PIN_SELECT = 6;
   localparam logic [7:0] MASK_PINCFG = 8'hcf;
   localparam logic [7:0] RESET_PINCFG = 8'h00;
   // optical configuration fields
   localparam int POS_RX_INVERT = 1;
   localparam int POS_DUTY_SELECT = 4;
   localparam logic [7:0] MASK_OPTCFG = 8'h32;
   localparam logic [7:0] RESET_OPTCFG = 8'h00;
   // status fields
   localparam int POS_ST_RX_LEVEL = 0;
   localparam int POS_ST_BROWNOUT = 1;
   localparam int POS_ST_CARRIER = 2;
   localparam int POS_ST_I2C_MODE = 3;

   localparam logic [1:0] EEPROM_SEL_I2C = 2'h1;
   localparam logic [1:0] TX_SEL_ACTIVE = 2'h0;

   typedef enum logic [1:0] {
      OPC_DUTY_50 = 2'h0,
      OPC_DUTY_25 = 2'h1,
      OPC_DUTY_12 = 2'h2,
      OPC_DUTY_6 = 2'h3
   } opc_duty_t;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // carrier timing
   localparam int CLK_HZ = 125_000_000;
   localparam int CARRIER_HZ = 38_000;
   localparam int CARRIER_PERIOD_CYC = CLK_HZ / CARRIER_HZ;
   localparam logic [11:0] CARRIER_LAST = 12'(CARRIER_PERIOD_CYC - 1);
   localparam logic [11:0] CARRIER_LOW_50 = 12'(CARRIER_PERIOD_CYC / 2);
   localparam logic [11:0] CARRIER_LOW_25 = 12'(CARRIER_PERIOD_CYC / 4);
   localparam logic [11:0] CARRIER_LOW_12 = 12'(CARRIER_PERIOD_CYC / 8);
   localparam logic [11:0] CARRIER_LOW_6 = 12'(CARRIER_PERIOD_CYC / 16);
endpackage : opc_pkg

// ---- opc_carrier.sv ----
// carrier generator: low for the selected fraction of each period, high otherwise
// assumes run and duty_select come from logic on mclk
`timescale 1ns/1ps
module opc_carrier
   import opc_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic run,
   input wire opc_duty_t duty_select,
   output logic carrier
);
   typedef struct packed {
      logic [11:0] cnt;
      logic level;
   } opc_car_state_t;

   opc_car_state_t st;
   opc_car_state_t next_st;
   logic [11:0] low_cyc;

   always_comb
   begin
      case (duty_select)
         OPC_DUTY_50: low_cyc = CARRIER_LOW_50;
         OPC_DUTY_25: low_cyc = CARRIER_LOW_25;
         OPC_DUTY_12: low_cyc = CARRIER_LOW_12;
         OPC_DUTY_6: low_cyc = CARRIER_LOW_6;
         default: low_cyc = CARRIER_LOW_50;
      endcase
      next_st = st;
      if (!run)
      begin
         next_st.cnt = 12'h000;
         next_st.level = 1'b1;
      end
      else
      begin
         next_st.cnt = (st.cnt == CARRIER_LAST) ? 12'h000 : st.cnt + 12'h001;
         next_st.level = (next_st.cnt < low_cyc) ? 1'b0 : 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         st <= '{cnt: 12'h000, level: 1'b1};
      else
         st <= next_st;
   end

   assign carrier = st.level;
endmodule : opc_carrier

// ---- opc_pin_control.sv ----
// optical port and shared eeprom pin control with an AXI4-Lite register slave
// assumes uart and eeprom controller signals on mclk; pins and brownout are asynchronous
`timescale 1ns/1ps
module opc_pin_control
   import opc_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   // AXI4-Lite slave
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // second serial port side
   input wire logic uart_tx_data,
   output logic uart_rx_data,
   // power state
   input wire logic brownout_mode,
   // optical pins
   output logic optical_tx_pin_out,
   output logic optical_tx_pin_oe,
   input wire logic optical_rx_pin,
   // eeprom controller side, open drain: drive_low pulls the line low
   input wire logic i2c_scl_drive_low,
   input wire logic i2c_sda_drive_low,
   output logic i2c_scl_in,
   output logic i2c_sda_in,
   // general digital io side of the shared pins
   input wire logic dio2_out,
   input wire logic dio2_oe,
   input wire logic dio3_out,
   input wire logic dio3_oe,
   output logic dio2_in,
   output logic dio3_in,
   // shared pins
   output logic shared_pin_two_out,
   output logic shared_pin_two_oe,
   input wire logic shared_pin_two_in,
   output logic shared_pin_three_out,
   output logic shared_pin_three_oe,
   input wire logic shared_pin_three_in
);
   typedef struct packed {
      // bus side
      logic aw_held;
      logic [15:0] awaddr;
      logic w_held;
      logic [7:0] wdata;
      logic wlane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      // software configuration
      logic [7:0] pincfg;
      logic [7:0] optcfg;
      // two-stage synchronisers
      logic rx_s1;
      logic rx_s2;
      logic brn_s1;
      logic brn_s2;
      logic p2_s1;
      logic p2_s2;
      logic p3_s1;
      logic p3_s2;
      // registered pin and port drivers
      logic rx_data;
      logic tx_out;
      logic tx_oe;
      logic p2_out;
      logic p2_oe;
      logic p3_out;
      logic p3_oe;
   } opc_state_t;

   opc_state_t st;
   opc_state_t next_st;
   logic carrier;
   logic mod_active;
   logic i2c_mode;
   logic aw_hs;
   logic w_hs;
   logic [15:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_lane0;
   logic tx_level;
   logic [31:0] status_word;

   assign mod_active = st.pincfg[POS_TX_MODULATE_EN] & ~st.brn_s2;
   assign i2c_mode = st.pincfg[POS_EEPROM_PIN_SELECT +: 2] == EEPROM_SEL_I2C;

   opc_carrier u_carrier (
      .mclk(mclk),
      .resetn(resetn),
      .run(mod_active),
      .duty_select(opc_duty_t'(st.optcfg[POS_DUTY_SELECT +: 2])),
      .carrier(carrier)
   );

   // readies drop while a response waits, so a second write cannot overtake it
   assign s_axi_awready = ~st.aw_held & ~st.bvalid;
   assign s_axi_wready = ~st.w_held & ~st.bvalid;
   assign s_axi_arready = ~st.rvalid;
   assign aw_hs = s_axi_awvalid & s_axi_awready;
   assign w_hs = s_axi_wvalid & s_axi_wready;
   assign wr_addr = st.aw_held ? st.awaddr : s_axi_awaddr;
   assign wr_data = st.w_held ? st.wdata : s_axi_wdata[7:0];
   assign wr_lane0 = st.w_held ? st.wlane0 : s_axi_wstrb[0];

   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[POS_ST_RX_LEVEL] = st.rx_data;
      status_word[POS_ST_BROWNOUT] = st.brn_s2;
      status_word[POS_ST_CARRIER] = mod_active;
      status_word[POS_ST_I2C_MODE] = i2c_mode;

      next_st = st;

      // pin synchronisers
      next_st.rx_s1 = optical_rx_pin;
      next_st.rx_s2 = st.rx_s1;
      next_st.brn_s1 = brownout_mode;
      next_st.brn_s2 = st.brn_s1;
      next_st.p2_s1 = shared_pin_two_in;
      next_st.p2_s2 = st.p2_s1;
      next_st.p3_s1 = shared_pin_three_in;
      next_st.p3_s2 = st.p3_s1;

      // write channel: address and data taken in either order
      if (aw_hs)
      begin
         next_st.aw_held = 1'b1;
         next_st.awaddr = s_axi_awaddr;
      end
      if (w_hs)
      begin
         next_st.w_held = 1'b1;
         next_st.wdata = s_axi_wdata[7:0];
         next_st.wlane0 = s_axi_wstrb[0];
      end
      if ((st.aw_held | aw_hs) && (st.w_held | w_hs))
      begin
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = RESP_OKAY;
         case (wr_addr)
            ADDR_PINCFG:
            begin
               if (wr_lane0)
                  next_st.pincfg = wr_data & MASK_PINCFG;
            end
            ADDR_OPTCFG:
            begin
               if (wr_lane0)
                  next_st.optcfg = wr_data & MASK_OPTCFG;
            end
            ADDR_STATUS:
            begin
               // read only: the write is answered and dropped
               next_st.bresp = RESP_OKAY;
            end
            default:
            begin
               next_st.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (st.bvalid && s_axi_bready)
         next_st.bvalid = 1'b0;

      // read channel
      if (st.rvalid && s_axi_rready)
         next_st.rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_st.rvalid = 1'b1;
         next_st.rresp = RESP_OKAY;
         case (s_axi_araddr)
            ADDR_PINCFG:
            begin
               next_st.rdata = {24'h000000, st.pincfg};
            end
            ADDR_OPTCFG:
            begin
               next_st.rdata = {24'h000000, st.optcfg};
            end
            ADDR_STATUS:
            begin
               next_st.rdata = status_word;
            end
            default:
            begin
               next_st.rdata = 32'h0000_0000;
               next_st.rresp = RESP_SLVERR;
            end
         endcase
      end

      // receive path with optional inversion
      next_st.rx_data = st.rx_s2 ^ st.optcfg[POS_RX_INVERT];

      // transmit path: carrier gated by active-low data, then inversion
      // inversion comes last so that it flips the idle level as well
      tx_level = mod_active ? (uart_tx_data | carrier) : uart_tx_data;
      next_st.tx_out = tx_level ^ st.pincfg[POS_TX_INVERT];
      next_st.tx_oe = st.pincfg[POS_TX_PIN_SELECT +: 2] == TX_SEL_ACTIVE;

      // shared pins: open-drain I2C or plain digital io
      // in I2C mode the pin is only ever pulled low; the pull-up makes the high
      if (i2c_mode)
      begin
         next_st.p2_out = 1'b0;
         next_st.p2_oe = i2c_scl_drive_low;
         next_st.p3_out = 1'b0;
         next_st.p3_oe = i2c_sda_drive_low;
      end
      else
      begin
         next_st.p2_out = dio2_out;
         next_st.p2_oe = dio2_oe;
         next_st.p3_out = dio3_out;
         next_st.p3_oe = dio3_oe;
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         st.aw_held <= 1'b0;
         st.awaddr <= 16'h0000;
         st.w_held <= 1'b0;
         st.wdata <= 8'h00;
         st.wlane0 <= 1'b0;
         st.bvalid <= 1'b0;
         st.bresp <= RESP_OKAY;
         st.rvalid <= 1'b0;
         st.rdata <= 32'h0000_0000;
         st.rresp <= RESP_OKAY;
         st.pincfg <= RESET_PINCFG;
         st.optcfg <= RESET_OPTCFG;
         st.rx_s1 <= 1'b1;
         st.rx_s2 <= 1'b1;
         st.brn_s1 <= 1'b0;
         st.brn_s2 <= 1'b0;
         st.p2_s1 <= 1'b1;
         st.p2_s2 <= 1'b1;
         st.p3_s1 <= 1'b1;
         st.p3_s2 <= 1'b1;
         st.rx_data <= 1'b1;
         st.tx_out <= 1'b1;
         st.tx_oe <= 1'b0;
         st.p2_out <= 1'b0;
         st.p2_oe <= 1'b0;
         st.p3_out <= 1'b0;
         st.p3_oe <= 1'b0;
      end
      else
         st <= next_st;
   end

   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign uart_rx_data = st.rx_data;
   assign optical_tx_pin_out = st.tx_out;
   assign optical_tx_pin_oe = st.tx_oe;
   assign shared_pin_two_out = st.p2_out;
   assign shared_pin_two_oe = st.p2_oe;
   assign shared_pin_three_out = st.p3_out;
   assign shared_pin_three_oe = st.p3_oe;
   assign i2c_scl_in = st.p2_s2;
   assign i2c_sda_in = st.p3_s2;
   assign dio2_in = st.p2_s2;
   assign dio3_in = st.p3_s2;
endmodule : opc_pin_control

// ---- opc_pin_control_asserts.sv ----
// port checker for the optical port pin control block
// assumes it is bound to every opc_pin_control instance, one mclk domain
`timescale 1ns/1ps
module opc_pin_control_asserts
   import opc_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic dio2_in,
   input wire logic i2c_scl_in,
   input wire logic shared_pin_two_in
);
   logic aw_bad;
   logic ar_bad;
   assign aw_bad = !(s_axi_awaddr inside {ADDR_PINCFG, ADDR_OPTCFG, ADDR_STATUS});
   assign ar_bad = !(s_axi_araddr inside {ADDR_PINCFG, ADDR_OPTCFG, ADDR_STATUS});
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   wr_answer_a: assert property (wr_take |=> s_axi_bvalid)
      else $error("no write response");
   rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
      else $error("no read response");
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h0)
      else $error("read channel misbehaves");
   bad_write_a: assert property (wr_take ##0 aw_bad |=> s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   bad_read_a: assert property (rd_take ##0 ar_bad |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 0)
      else $error("unmapped read not refused");
   pin_sync_a: assert property (
      dio2_in == $past(shared_pin_two_in, 2) && i2c_scl_in == dio2_in)
      else $error("shared pin views differ");
endmodule : opc_pin_control_asserts

bind opc_pin_control opc_pin_control_asserts u_opc_pin_control_asserts (.mclk, .resetn,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dio2_in, .i2c_scl_in, .shared_pin_two_in);

// ---- opc_optical_model.sv ----
// optical emitter and phototransistor seen from the pins
// assumes pin levels change only at mclk edges; a disabled emitter stays dark (high)
`timescale 1ns/1ps
module opc_optical_model
(
   input wire logic mclk,
   input wire logic optical_tx_pin_out,
   input wire logic optical_tx_pin_oe,
   input wire logic light,
   output logic optical_rx_pin,
   output int low_len,
   output int period,
   output int rises
);
   int run = 0;
   int since = 0;
   logic prev = 1'b1;
   logic v;
   assign v = optical_tx_pin_oe ? optical_tx_pin_out : 1'b1;
   assign optical_rx_pin = light;
   // measure low run, fall-to-fall period and rising edges of the emitter
   always @(posedge mclk)
   begin
      since <= since + 1;
      if (!v)
         run <= run + 1;
      if (v && !prev)
      begin
         low_len <= run;
         run <= 0;
         rises <= rises + 1;
      end
      if (!v && prev)
      begin
         period <= since;
         since <= 1;
      end
      prev <= v;
   end
endmodule : opc_optical_model

// ---- tb_opc_pin_control.sv ----
// self-checking bench for opc_pin_control with an optical partner
// assumes 125 MHz mclk; shared pins have pull-ups
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_opc_pin_control;
   import opc_pkg::*;
   logic mclk = 0, resetn = 0, light = 1, brownout_mode = 0, uart_tx_data = 1;
   logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, uart_rx_data;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic optical_tx_pin_out, optical_tx_pin_oe, optical_rx_pin, i2c_scl_in, i2c_sda_in;
   logic i2c_scl_drive_low = 0, i2c_sda_drive_low = 0, dio2_out = 0, dio2_oe = 0, dio3_out = 0;
   logic dio3_oe = 0, dio2_in, dio3_in, shared_pin_two_out, shared_pin_two_oe;
   logic shared_pin_three_out, shared_pin_three_oe, shared_pin_two_in, shared_pin_three_in;
   int low_len, period, rises, n, n_fail = 0, checks_done = 0, cycles = 0;
   logic [1:0] wq[$];
   logic [33:0] rq[$];
   logic slow = 1'b0;
   assign shared_pin_two_in = shared_pin_two_oe ? shared_pin_two_out : 1'b1;
   assign shared_pin_three_in = shared_pin_three_oe ? shared_pin_three_out : 1'b1;
   always #4 mclk = ~mclk;
   opc_pin_control u_opc_pin_control (.mclk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .uart_tx_data, .uart_rx_data,
      .brownout_mode, .optical_tx_pin_out, .optical_tx_pin_oe, .optical_rx_pin,
      .i2c_scl_drive_low, .i2c_sda_drive_low, .i2c_scl_in, .i2c_sda_in, .dio2_out, .dio2_oe,
      .dio3_out, .dio3_oe, .dio2_in, .dio3_in, .shared_pin_two_out, .shared_pin_two_oe,
      .shared_pin_two_in, .shared_pin_three_out, .shared_pin_three_oe, .shared_pin_three_in);
   opc_optical_model u_opc_optical_model (.mclk, .optical_tx_pin_out, .optical_tx_pin_oe,
      .light, .optical_rx_pin, .low_len, .period, .rises);

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   task automatic tick(input int c);
      repeat (c) @(posedge mclk);
   endtask : tick

   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
      logic ta, tw, tb, tv;
      wq.push_back(r);
      slow = ~slow;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'($urandom), d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= ~slow;
      do
      begin
         @(negedge mclk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         tb = s_axi_bvalid & s_axi_bready;
         tv = s_axi_bvalid;
         @(posedge mclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) s_axi_bready <= 1'b0;
         else if (tv) s_axi_bready <= 1'b1;
      end while (!tb);
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [1:0] r, input logic [7:0] d);
      logic ta, tr, tv;
      rq.push_back({r, 24'h0, d});
      slow = ~slow;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= ~slow;
      do
      begin
         @(negedge mclk);
         ta = s_axi_arready;
         tr = s_axi_rvalid & s_axi_rready;
         tv = s_axi_rvalid;
         @(posedge mclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) s_axi_rready <= 1'b0;
         else if (tv) s_axi_rready <= 1'b1;
      end while (!tr);
   endtask : rd

   // answers are checked against the oldest note when they are accepted
   always @(posedge mclk)
   begin
      cycles++;
      if (s_axi_bvalid && s_axi_bready)
         `CHK(s_axi_bresp, wq.pop_front())
      if (s_axi_rvalid && s_axi_rready)
         `CHK({s_axi_rresp, s_axi_rdata}, rq.pop_front())
      if (cycles == 80000)
      begin
         n_fail++;
         give_verdict();
      end
   end

   initial
   begin
      void'($urandom(32'h4bbc));
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      tick(2);
      `CHK(optical_tx_pin_oe, 1'b1)
      rd(ADDR_PINCFG, RESP_OKAY, RESET_PINCFG);
      for (int s = 0; s < 4; s++)
      begin
         wr(ADDR_PINCFG, 8'(s << 2) | 8'h30, RESP_OKAY);
         tick(2);
         `CHK(optical_tx_pin_oe, 1'(s == 0))
         rd(ADDR_PINCFG, RESP_OKAY, 8'(s << 2));
      end
      wr(ADDR_PINCFG, 8'h01, RESP_OKAY);
      tick(2);
      `CHK(optical_tx_pin_out, 1'b0)
      `CHK(uart_rx_data, 1'b1)
      wr(ADDR_OPTCFG, 8'h02, RESP_OKAY);
      tick(5);
      `CHK(uart_rx_data, 1'b0)
      light <= 1'b0;
      tick(4);
      `CHK(uart_rx_data, 1'b1)
      light <= 1'b1;
      uart_tx_data <= 1'b0;
      wr(ADDR_PINCFG, 8'h02, RESP_OKAY);
      for (int d = 0; d < 4; d++)
      begin
         wr(ADDR_OPTCFG, 8'(d << 4), RESP_OKAY);
         tick(2 * CARRIER_PERIOD_CYC + 20);
         `CHK(low_len, CARRIER_PERIOD_CYC >> (d + 1))
         `CHK(period, CARRIER_PERIOD_CYC)
      end
      uart_tx_data <= 1'b1;
      tick(5);
      n = rises;
      tick(4000);
      `CHK(rises - n, 0)
      uart_tx_data <= 1'b0;
      brownout_mode <= 1'b1;
      tick(5);
      n = rises;
      tick(4000);
      `CHK(rises - n, 0)
      rd(ADDR_STATUS, RESP_OKAY, 8'h03);
      brownout_mode <= 1'b0;
      n = rises;
      tick(4000);
      `CHK(rises != n, 1'b1)
      wr(ADDR_PINCFG, 8'h00, RESP_OKAY);
      tick(5);
      n = rises;
      tick(4000);
      `CHK(rises - n, 0)
      wr(ADDR_PINCFG, 8'h40, RESP_OKAY);
      i2c_scl_drive_low <= 1'b1;
      i2c_sda_drive_low <= 1'b1;
      tick(6);
      `CHK({shared_pin_two_oe, shared_pin_two_out, shared_pin_three_oe}, 3'b101)
      `CHK(i2c_scl_in, 1'b0)
      `CHK({i2c_sda_in, dio3_in, dio2_in}, 3'b000)
      dio2_oe <= 1'b1;
      dio2_out <= 1'($urandom);
      dio3_oe <= 1'b1;
      dio3_out <= 1'($urandom);
      wr(ADDR_PINCFG, 8'h80, RESP_OKAY);
      tick(3);
      `CHK(shared_pin_two_out, dio2_out)
      `CHK({shared_pin_two_oe, shared_pin_three_oe, shared_pin_three_out}, {2'b11, dio3_out})
      rd(16'h0000, RESP_SLVERR, 8'h00);
      wr(16'h0004, 8'hff, RESP_SLVERR);
      tick(2);
      give_verdict();
   end
endmodule : tb_opc_pin_control
